// file: src/trig_router_pkg.sv
/*
 trig_router_pkg: register map, field layouts, reset values, mode codes
 and packed carriers of the trigger and timing router.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package trig_router_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_SRC_SEL0 = 8'h08;
  localparam logic [7:0] ADDR_SRC_SEL1 = 8'h0c;
  localparam logic [7:0] ADDR_SRC_SEL2 = 8'h10;
  localparam logic [7:0] ADDR_SRC_SEL3 = 8'h14;
  localparam logic [7:0] ADDR_PIN_OE = 8'h18;
  localparam logic [7:0] ADDR_PIN_SEL0 = 8'h1c;
  localparam logic [7:0] ADDR_PIN_SEL1 = 8'h20;
  localparam logic [7:0] ADDR_BUS_CTRL = 8'h24;
  localparam logic [7:0] ADDR_BUS_SEL = 8'h28;
  localparam logic [7:0] ADDR_DIG_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;

  localparam int NUM_TIMING = 13;
  localparam int NUM_FPIN = 10;
  localparam int NUM_BUSLINE = 7;
  localparam int NUM_BUS_SIG = 8;
  localparam int NUM_DIG = 8;
  localparam int NUM_INT_SRC = 8;
  localparam int NUM_DIG_GROUP = 2;

  // source select code: 0..6 bus lines, 7..16 function pins,
  // 17..24 internal sources, 25 analog trigger
  localparam logic [4:0] SRC_BUS0 = 5'h00;
  localparam logic [4:0] SRC_PIN0 = 5'h07;
  localparam logic [4:0] SRC_INT0 = 5'h11;
  localparam logic [4:0] SRC_ANALOG = 5'h19;
  localparam logic [4:0] SRC_SEL_RST = 5'h1f;

  // internal source index of scan interval terminal count and counter0 out
  localparam int INT_SCAN_TC = 0;
  localparam int INT_CNT0_OUT = 1;

  // trigger control fields
  localparam int TC_MODE_LSB = 0;
  localparam int TC_SRC_BIT = 3;
  localparam int TC_CHAN_LSB = 4;
  localparam int TC_WIDE_BIT = 6;
  localparam logic [31:0] TRIG_CTRL_RST = 32'h0000_0000;

  // threshold: lower in [15:0], upper in [31:16]; 16-bit variant codes
  // span 4,096 steps of the channel range, 12-bit variant 256 steps.
  localparam int LEVEL_W = 16;
  localparam int DIRECT_W16 = 12;
  localparam int DIRECT_W12 = 8;
  localparam logic [31:0] THRESH_RST = 32'hffff_0000;

  localparam int BC_TB_EXT_BIT = 0;
  localparam int BC_TB_DRIVE_BIT = 1;
  localparam logic [31:0] BUS_CTRL_RST = 32'h0000_0000;

  localparam logic [31:0] PIN_OE_RST = 32'h0000_0000;
  localparam logic [31:0] BUS_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] DIG_CTRL_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_BELOW_LOW = 3'h0,
    MODE_ABOVE_HIGH = 3'h1,
    MODE_INSIDE = 3'h3,
    MODE_HYST_HIGH = 3'h2,
    MODE_HYST_LOW = 3'h6
  } trig_mode_t;

  typedef struct packed {
    logic [NUM_BUSLINE-1:0] busIn;
    logic [NUM_FPIN-1:0] pinIn;
    logic [NUM_INT_SRC-1:0] intSrc;
  } route_src_t;

  typedef struct packed {
    logic [NUM_BUSLINE-1:0] o;
    logic [NUM_BUSLINE-1:0] oeN;
  } bus_drive_t;

endpackage : trig_router_pkg

// file: src/trigger_and_timing_router.sv
/*
 trigger_and_timing_router: window comparator for the analog trigger,
 source multiplexers for the internal timing signals, function pin and
 trigger bus drivers, timebase selection and digital line output enables.
 Assumes synchronous pins and an APB master on sys_clk; the analog levels
 arrive already digitised as signed samples.
*/
// Local design decisions: register access over APB and the placing of the registers.
// Function
// - analog trigger source: direct trigger pin or post-gain of a chosen channel
// - direct pin level spans +-10 V in 78 mV or 4.88 mV steps
// - post-gain threshold spans channel range in 256 or 4,096 steps
// - lower and upper thresholds are programmed independently
// - below-low: trigger while signal under lower threshold
// - above-high: trigger while signal over upper threshold
// - inside-region: trigger while signal between both thresholds
// - high-hysteresis: trigger on exceeding upper, lower is hysteresis
// - low-hysteresis: trigger on falling under lower, upper is hysteresis
// - comparator result is a selectable source for timing and counters
// - each of 13 timing signals has a software source multiplexer
// - scan start picks bus lines, function pins, scan tc or counter0
// - every function pin feeds every timing multiplexer
// - each function pin has an output enable driving one timing signal
// - timebase is internal 20 MHz or received from the trigger bus
// - timebase drives the bus only while internal timebase selected
// - after startup internal timebase, bus timebase not driven
// - seven bidirectional bus lines each drive or receive eight signals
// - backplane: lines 0..5 to backplane 0..5, line 6 to star trigger
// - eight digital lines set in groups as inputs or outputs
// - at startup and reset all digital line drivers are off
// - digital lines six and seven also feed counter direction inputs
`timescale 1ns/1ps
module trigger_and_timing_router
  import trig_router_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LEVEL_W-1:0] analogTriggerPin,
  input wire logic [LEVEL_W-1:0] chanSample [4],
  input wire route_src_t routeSrc,
  input wire logic [NUM_TIMING-1:0] timingInt,
  input wire logic internalTimebase,
  input wire logic busTimebaseIn,
  input wire logic [NUM_DIG-1:0] digitalLineOut,
  input wire logic [NUM_DIG-1:0] digitalLineIn,
  output logic [NUM_TIMING-1:0] timingSel,
  output logic analogTrigger,
  output logic primaryTimebase,
  output logic busTimebaseOut,
  output logic busTimebaseOeN,
  output bus_drive_t busDrive,
  output logic [NUM_FPIN-1:0] functionPinOut,
  output logic [NUM_FPIN-1:0] functionPinOeN,
  output logic [NUM_DIG-1:0] digitalLineDrv,
  output logic [NUM_DIG-1:0] digitalLineOeN,
  output logic counter0Direction,
  output logic counter1Direction
);

  // configuration registers, all written through apb, then the hysteresis state and apb decode signals
  logic [31:0] trigCtrl_r;
  logic [31:0] thresh_r;
  logic [4:0] srcSel_r [NUM_TIMING];
  logic [NUM_FPIN-1:0] pinOe_r;
  logic [3:0] pinSel_r [NUM_FPIN];
  logic [31:0] busCtrl_r;
  logic [2:0] busSel_r [NUM_BUSLINE];
  logic [NUM_BUSLINE-1:0] busOe_r;
  logic [NUM_DIG_GROUP-1:0] digDir_r;
  logic hystState_r;
  logic [31:0] rdMux;
  logic wrEn;
  logic addrOk;

  // a write lands at the access edge, when pready is already high
  assign wrEn = psel && penable && pwrite;

  // apb: single-cycle access phase, unmapped addresses answer pslverr
  always_comb begin
    rdMux = 32'h0000_0000;
    addrOk = 1'b1;
    case (paddr)
      ADDR_TRIG_CTRL: rdMux = trigCtrl_r;
      ADDR_THRESH: rdMux = thresh_r;
      ADDR_SRC_SEL0: rdMux = {3'h0, srcSel_r[3], 3'h0, srcSel_r[2], 3'h0,
        srcSel_r[1], 3'h0, srcSel_r[0]};
      ADDR_SRC_SEL1: rdMux = {3'h0, srcSel_r[7], 3'h0, srcSel_r[6], 3'h0,
        srcSel_r[5], 3'h0, srcSel_r[4]};
      ADDR_SRC_SEL2: rdMux = {3'h0, srcSel_r[11], 3'h0, srcSel_r[10],
        3'h0, srcSel_r[9], 3'h0, srcSel_r[8]};
      ADDR_SRC_SEL3: rdMux = {27'h0, srcSel_r[12]};
      ADDR_PIN_OE: rdMux = {22'h0, pinOe_r};
      ADDR_PIN_SEL0: rdMux = {pinSel_r[7], pinSel_r[6], pinSel_r[5],
        pinSel_r[4], pinSel_r[3], pinSel_r[2], pinSel_r[1], pinSel_r[0]};
      ADDR_PIN_SEL1: rdMux = {24'h0, pinSel_r[9], pinSel_r[8]};
      ADDR_BUS_CTRL: rdMux = busCtrl_r;
      ADDR_BUS_SEL: rdMux = {4'h0, busOe_r, busSel_r[6], busSel_r[5],
        busSel_r[4], busSel_r[3], busSel_r[2], busSel_r[1], busSel_r[0]};
      ADDR_DIG_CTRL: rdMux = {30'h0, digDir_r};
      // status is read-only; a write to it is answered and dropped
      ADDR_STATUS: rdMux = {7'h0, analogTrigger, digitalLineIn,
        3'h0, timingSel};
      // unaligned and unmapped addresses fall here and are refused
      default: addrOk = 1'b0;
    endcase
  end

  // every setup is answered in the next cycle; prdata only stands then
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // lanes without a strobe keep their current contents
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // the read mux doubles as the old value for partial writes
  logic [31:0] wv;
  assign wv = merge(rdMux, pwdata, pstrb);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trigCtrl_r <= TRIG_CTRL_RST;
      thresh_r <= THRESH_RST;
    end else if (wrEn && pready) begin
      // reserved bits are dropped so that they read back as zero
      if (paddr == ADDR_TRIG_CTRL) begin
        trigCtrl_r <= {25'h0, wv[6:0]};
      end
      if (paddr == ADDR_THRESH) begin
        thresh_r <= wv;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busCtrl_r <= BUS_CTRL_RST;
      pinOe_r <= PIN_OE_RST[NUM_FPIN-1:0];
      busOe_r <= BUS_SEL_RST[27:21];
      digDir_r <= DIG_CTRL_RST[NUM_DIG_GROUP-1:0];
    end else if (wrEn && pready) begin
      if (paddr == ADDR_BUS_CTRL) begin
        busCtrl_r <= {30'h0, wv[1:0]};
      end
      if (paddr == ADDR_PIN_OE) begin
        pinOe_r <= wv[NUM_FPIN-1:0];
      end
      if (paddr == ADDR_BUS_SEL) begin
        busOe_r <= wv[27:21];
      end
      if (paddr == ADDR_DIG_CTRL) begin
        digDir_r <= wv[NUM_DIG_GROUP-1:0];
      end
    end
  end

  // per-entry select registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMING; gi++) begin : g_srcsel
      localparam logic [7:0] A = ADDR_SRC_SEL0 + 8'((gi / 4) * 4);
      localparam int L = (gi % 4) * 8;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          srcSel_r[gi] <= SRC_SEL_RST;
        end else if (wrEn && pready && paddr == A) begin
          srcSel_r[gi] <= wv[L +: 5];
        end
      end
    end
    // pin selects: eight 4-bit timing indices to a word
    for (gi = 0; gi < NUM_FPIN; gi++) begin : g_pinsel
      localparam logic [7:0] A = ADDR_PIN_SEL0 + 8'((gi / 8) * 4);
      localparam int L = (gi % 8) * 4;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          pinSel_r[gi] <= 4'h0;
        end else if (wrEn && pready && paddr == A) begin
          pinSel_r[gi] <= wv[L +: 4];
        end
      end
    end
    // bus line selects share their word with the drive enables
    for (gi = 0; gi < NUM_BUSLINE; gi++) begin : g_bussel
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          busSel_r[gi] <= 3'h0;
        end else if (wrEn && pready && paddr == ADDR_BUS_SEL) begin
          busSel_r[gi] <= wv[gi*3 +: 3];
        end
      end
    end
  endgenerate

  // analog comparator
  // thresholds and samples are two's complement, so compares are signed
  logic signed [LEVEL_W-1:0] level;
  logic signed [LEVEL_W-1:0] lowerThreshold;
  logic signed [LEVEL_W-1:0] upperThreshold;
  logic [LEVEL_W-1:0] rawLevel;
  logic [LEVEL_W-1:0] qMask;
  logic belowLow;
  logic aboveHigh;
  trig_mode_t mode;

  assign mode = trig_mode_t'(trigCtrl_r[TC_MODE_LSB +: 3]);
  assign rawLevel = trigCtrl_r[TC_SRC_BIT] ?
    chanSample[trigCtrl_r[TC_CHAN_LSB +: 2]] : analogTriggerPin;
  // keep only the comparator's resolution; low bits are below one step
  assign qMask = trigCtrl_r[TC_WIDE_BIT] ?
    ~((16'h1 << (LEVEL_W - DIRECT_W16)) - 16'h1) :
    ~((16'h1 << (LEVEL_W - DIRECT_W12)) - 16'h1);
  assign level = rawLevel & qMask;
  assign lowerThreshold = thresh_r[15:0] & qMask;
  assign upperThreshold = thresh_r[31:16] & qMask;
  assign belowLow = level < lowerThreshold;
  assign aboveHigh = level > upperThreshold;

  // a new mode or source starts released, so no latched state leaks in
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hystState_r <= 1'b0;
    end else if (wrEn && pready && paddr == ADDR_TRIG_CTRL) begin
      hystState_r <= 1'b0;
    end else begin
      case (mode)
        MODE_HYST_HIGH: begin
          if (aboveHigh) begin
            hystState_r <= 1'b1;
          end else if (belowLow) begin
            hystState_r <= 1'b0;
          end
        end
        MODE_HYST_LOW: begin
          if (belowLow) begin
            hystState_r <= 1'b1;
          end else if (aboveHigh) begin
            hystState_r <= 1'b0;
          end
        end
        default: hystState_r <= 1'b0;
      endcase
    end
  end

  // registered once below, so the trigger trails its sample by one cycle
  logic trigNxt;
  always_comb begin
    case (mode)
      MODE_BELOW_LOW: trigNxt = belowLow;
      MODE_ABOVE_HIGH: trigNxt = aboveHigh;
      MODE_INSIDE: trigNxt = !belowLow && !aboveHigh &&
        lowerThreshold <= upperThreshold;
      MODE_HYST_HIGH: trigNxt = aboveHigh || (hystState_r && !belowLow);
      MODE_HYST_LOW: trigNxt = belowLow || (hystState_r && !aboveHigh);
      default: trigNxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      analogTrigger <= 1'b0;
    end else begin
      analogTrigger <= trigNxt;
    end
  end

  // timing source multiplexers; bus inputs are what line 6 carries
  // from the star trigger in backplane form
  // codes above 25 select a constant zero, the value after reset
  logic [31:0] srcVec;
  assign srcVec = {6'h0, analogTrigger, routeSrc.intSrc, routeSrc.pinIn,
    routeSrc.busIn};
  logic [NUM_TIMING-1:0] selNxt;
  generate
    for (gi = 0; gi < NUM_TIMING; gi++) begin : g_tmux
      assign selNxt[gi] = srcVec[srcSel_r[gi]];
    end
  endgenerate

  // one register stage on every timing output
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timingSel <= '0;
    end else begin
      timingSel <= selNxt;
    end
  end

  // pin and bus drivers; first eight timing signals are the bus set
  logic [NUM_FPIN-1:0] pinNxt;
  logic [NUM_BUSLINE-1:0] busNxt;
  generate
    for (gi = 0; gi < NUM_FPIN; gi++) begin : g_pin
      // indices 13..15 name no timing signal and must not read past the end
      assign pinNxt[gi] = (pinSel_r[gi] < 4'(NUM_TIMING)) ?
        timingInt[pinSel_r[gi]] : 1'b0;
    end
    for (gi = 0; gi < NUM_BUSLINE; gi++) begin : g_bus
      assign busNxt[gi] = timingInt[busSel_r[gi]];
    end
  endgenerate

  // a board taking the bus timebase never drives it back onto the bus
  logic tbExt;
  assign tbExt = busCtrl_r[BC_TB_EXT_BIT];

  // data and enables move together so a pin never drives a stale value
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      functionPinOut <= '0;
      functionPinOeN <= '1;
      busDrive <= '{o: '0, oeN: '1};
      busTimebaseOut <= 1'b0;
      busTimebaseOeN <= 1'b1;
      primaryTimebase <= 1'b0;
    end else begin
      functionPinOut <= pinNxt;
      functionPinOeN <= ~pinOe_r;
      busDrive.o <= busNxt;
      busDrive.oeN <= ~busOe_r;
      primaryTimebase <= tbExt ? busTimebaseIn : internalTimebase;
      busTimebaseOut <= internalTimebase;
      busTimebaseOeN <= !(busCtrl_r[BC_TB_DRIVE_BIT] && !tbExt);
    end
  end

  // digital lines: group 0 is lines 0..3, group 1 is lines 4..7
  // taps read the pin side, so they follow the line in either direction
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      digitalLineDrv <= '0;
      digitalLineOeN <= '1;
      counter0Direction <= 1'b0;
      counter1Direction <= 1'b0;
    end else begin
      digitalLineDrv <= digitalLineOut;
      digitalLineOeN <= ~{{4{digDir_r[1]}}, {4{digDir_r[0]}}};
      counter0Direction <= digitalLineIn[6];
      counter1Direction <= digitalLineIn[7];
    end
  end

endmodule : trigger_and_timing_router

// file: tb/trig_router_checker.sv
/*
 trig_router_checker: port assertions for the trigger and timing router.
 Bound onto the top module and sees nothing but its ports.
*/
`timescale 1ns/1ps
module trig_router_checker
  import trig_router_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_DIG-1:0] digitalLineIn,
  input wire logic [NUM_DIG-1:0] digitalLineOeN,
  input wire logic primaryTimebase,
  input wire logic busTimebaseOut,
  input wire logic busTimebaseOeN,
  input wire logic counter0Direction,
  input wire logic counter1Direction
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_answer;
    s_setup |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_unmapped;
    pready && paddr > ADDR_STATUS |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  property p_mapped;
    pready && paddr <= ADDR_STATUS && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  property p_errdata;
    pready && (pslverr || pwrite) |-> prdata == 32'h0;
  endproperty
  a_errdata: assert property (p_errdata) else $error("read data not zero");
  property p_dir;
    1'b1 |=> {counter1Direction, counter0Direction} ==
      $past(digitalLineIn[7:6]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction tap wrong");
  property p_tbdrive;
    !busTimebaseOeN |-> primaryTimebase == busTimebaseOut;
  endproperty
  a_tbdrive: assert property (p_tbdrive) else $error("foreign tb driven");
  property p_rst;
    $rose(rstn) |-> digitalLineOeN == 8'hff && busTimebaseOeN;
  endproperty
  a_rst: assert property (p_rst) else $error("driver on at reset");
  property p_group;
    (&digitalLineOeN[3:0] || ~|digitalLineOeN[3:0]) &&
      (&digitalLineOeN[7:4] || ~|digitalLineOeN[7:4]);
  endproperty
  a_group: assert property (p_group) else $error("group split");
endmodule : trig_router_checker

// file: tb/bus_partner_model.sv
/*
 bus_partner_model: the other boards on the trigger bus.
 Resolves each pulled-up bus line from both parties' enables.
*/
`timescale 1ns/1ps
module bus_partner_model
  import trig_router_pkg::*;
(
  input wire bus_drive_t busDrive,
  input wire logic [NUM_BUSLINE-1:0] farVal,
  input wire logic [NUM_BUSLINE-1:0] farOeN,
  output logic [NUM_BUSLINE-1:0] busWire
);
  // pull-up: a line nobody drives reads high, never the last value
  always_comb begin
    for (int i = 0; i < NUM_BUSLINE; i++) begin
      if (!busDrive.oeN[i]) busWire[i] = busDrive.o[i];
      else if (!farOeN[i]) busWire[i] = farVal[i];
      else busWire[i] = 1'b1;
    end
  end
endmodule : bus_partner_model

// file: tb/testbench.sv
/*
 testbench: APB-driven checks of the trigger and timing router.
 Assumes the bus partner model on the trigger lines.
*/
`timescale 1ns/1ps
module testbench
  import trig_router_pkg::*;
;
  logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er, analogTrigger, primaryTimebase;
  logic internalTimebase = 1, busTimebaseIn = 0;
  logic busTimebaseOut, busTimebaseOeN, counter0Direction, counter1Direction;
  logic [15:0] analogTriggerPin = 16'h0;
  logic [15:0] chanSample [4] = '{default: 16'h0};
  logic [24:0] srcVec = 25'h0;
  logic [12:0] timingInt = 13'h0, timingSel;
  logic [7:0] digitalLineOut = 8'ha5, digitalLineIn = 8'h0;
  logic [7:0] digitalLineDrv, digitalLineOeN;
  logic [6:0] farOeN = 7'h7f, busWire;
  logic [9:0] functionPinOut, functionPinOeN;
  bus_drive_t busDrive;
  route_src_t routeSrc;
  int error_cnt = 0, n_checks = 0;
  logic [7:0] rstAddr [10] = '{ADDR_TRIG_CTRL, ADDR_THRESH, ADDR_SRC_SEL0,
    ADDR_SRC_SEL1, ADDR_SRC_SEL2, ADDR_SRC_SEL3, ADDR_PIN_OE, ADDR_BUS_CTRL,
    ADDR_BUS_SEL, ADDR_DIG_CTRL};
  logic [31:0] rstVal [10] = '{TRIG_CTRL_RST, THRESH_RST, 32'h1f1f1f1f,
    32'h1f1f1f1f, 32'h1f1f1f1f, 32'h1f, PIN_OE_RST, BUS_CTRL_RST,
    BUS_SEL_RST, DIG_CTRL_RST};
  trig_mode_t modeTab [5] = '{MODE_BELOW_LOW, MODE_ABOVE_HIGH, MODE_INSIDE,
    MODE_HYST_HIGH, MODE_HYST_LOW};
  logic [4:0] expTab [5] = '{5'h11, 5'h04, 5'h0a, 5'h0c, 5'h13};
  logic [15:0] smpTab [5] = '{16'hfe00, 16'h0200, 16'h0800, 16'h0200,
    16'hfe00};
  assign routeSrc = {busWire, srcVec[17:0]};
  trigger_and_timing_router dut (.sys_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .analogTriggerPin,
    .chanSample, .routeSrc, .timingInt, .internalTimebase, .busTimebaseIn,
    .digitalLineOut, .digitalLineIn, .timingSel, .analogTrigger,
    .primaryTimebase, .busTimebaseOut, .busTimebaseOeN, .busDrive,
    .functionPinOut, .functionPinOeN, .digitalLineDrv, .digitalLineOeN,
    .counter0Direction, .counter1Direction);
  bus_partner_model partner (.busDrive, .farVal(srcVec[24:18]), .farOeN,
    .busWire);
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // outputs are read at the edge, before that edge's updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      error_cnt++;
      $display("mismatch at %0t: no bus answer", $time);
      complete_run();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rd, e);
  endtask : rdchk
  task automatic outs_after_reset;
    cyc(2);
    chk(32'(digitalLineOeN), 32'hff);
    chk(32'({busTimebaseOeN, primaryTimebase}), 32'h3);
  endtask : outs_after_reset
  initial begin
    cyc(8);
    rstn <= 1'b1;
    outs_after_reset();
    for (int i = 0; i < 10; i++) rdchk(rstAddr[i], rstVal[i]);
    apb(1'b0, 8'h3c, 32'h0, 4'hf);
    chk({31'h0, er}, 32'h1);
    wr(ADDR_THRESH, 32'h0400_0100);
    apb(1'b1, ADDR_THRESH, 32'h1234_0290, 4'h3);
    rdchk(ADDR_THRESH, 32'h0400_0290);
    apb(1'b1, ADDR_BUS_CTRL, 32'hffff_fffc, 4'hf);
    rdchk(ADDR_BUS_CTRL, 32'h0);
    // resolution: 0x280 vs 0x290 differ only on the wide variant
    wr(ADDR_TRIG_CTRL, 32'h40);
    analogTriggerPin <= 16'h0280;
    cyc(2);
    chk(32'(analogTrigger), 32'h1);
    wr(ADDR_TRIG_CTRL, 32'h0);
    cyc(2);
    chk(32'(analogTrigger), 32'h0);
    wr(ADDR_TRIG_CTRL, 32'h68);
    analogTriggerPin <= 16'h0800;
    chanSample[1] <= 16'hfe00;
    chanSample[2] <= 16'hfe00;
    cyc(2);
    chk(32'(analogTrigger), 32'h1);
    chanSample[2] <= 16'h0800;
    cyc(2);
    chk(32'(analogTrigger), 32'h0);
    wr(ADDR_TRIG_CTRL, 32'h40);
    wr(ADDR_SRC_SEL0, 32'h1f1f1f19);
    analogTriggerPin <= 16'hfe00;
    cyc(3);
    chk(32'(timingSel[0]), 32'h1);
    analogTriggerPin <= 16'h0800;
    cyc(3);
    chk(32'(timingSel[0]), 32'h0);
    wr(ADDR_THRESH, 32'h0400_0100);
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_TRIG_CTRL, 32'h40 | 32'(modeTab[m]));
      for (int s = 0; s < 5; s++) begin
        analogTriggerPin <= smpTab[s];
        cyc(2);
        chk(32'(analogTrigger), 32'(expTab[m][s]));
      end
    end
    farOeN <= 7'h00;
    for (int c = 0; c < 25; c++) begin
      wr(ADDR_SRC_SEL0, {24'h1f1f1f, 8'(c)});
      wr(ADDR_SRC_SEL3, {24'h1f1f1f, 8'(c)});
      srcVec <= 25'h1 << (c < 7 ? 18 + c : c < 17 ? c + 1 : c - 17);
      cyc(2);
      chk(32'({timingSel[12], timingSel[0]}), 32'h3);
      srcVec <= 25'h0;
      cyc(2);
      chk(32'(timingSel), 32'h0);
    end
    farOeN <= 7'h7f;
    wr(ADDR_PIN_SEL0, 32'hc000_0005);
    wr(ADDR_PIN_OE, 32'h081);
    wr(ADDR_BUS_SEL, 32'h0080_00c0);
    wr(ADDR_SRC_SEL0, 32'h1f1f1f02);
    for (int k = 0; k < 2; k++) begin
      timingInt <= k ? 13'h0fd7 : 13'h1028;
      cyc(3);
      chk(32'(functionPinOeN), 32'h37e);
      chk(32'({functionPinOut[7], functionPinOut[0]}), k ? 0 : 3);
      chk(32'(busDrive.oeN), 32'h7b);
      chk(32'({busDrive.o[2], timingSel[0]}), k ? 0 : 3);
    end
    wr(ADDR_BUS_CTRL, 32'h2);
    cyc(2);
    chk(32'({busTimebaseOeN, busTimebaseOut, primaryTimebase}), 3);
    wr(ADDR_BUS_CTRL, 32'h3);
    cyc(2);
    chk(32'({busTimebaseOeN, primaryTimebase}), 32'h2);
    digitalLineIn <= 8'h40;
    wr(ADDR_DIG_CTRL, 32'h2);
    cyc(2);
    chk(32'(digitalLineOeN), 32'h0f);
    chk(32'(digitalLineDrv[7:4]), 32'ha);
    chk(32'({counter1Direction, counter0Direction}), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0, 4'hf);
    chk(32'(rd[23:16]), 32'h40);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    outs_after_reset();
    complete_run();
  end
endmodule : testbench
bind trigger_and_timing_router trig_router_checker chk_i (.sys_clk, .rstn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .digitalLineIn, .digitalLineOeN, .primaryTimebase, .busTimebaseOut,
  .busTimebaseOeN, .counter0Direction, .counter1Direction);
